// *** crre_consts.svh ***
// Constants for the call, return and reset execution block
`ifndef CRRE_CONSTS_SVH
`define CRRE_CONSTS_SVH
`define CRRE_RELATIVE_CALL_OP_TOP5      5'h1B
`define CRRE_SWRESET_WORD    16'h00FF
`define CRRE_IRET_TOP15      15'h0008
`define CRRE_LRET_TOP8       8'h0C
`define CRRE_PC_W            21
`define CRRE_PC_STEP         21'h000002
`define CRRE_PC_RESET        21'h000000
`define CRRE_ACC_RESET       8'h00
`define CRRE_FLAGS_RESET     5'h00
`define CRRE_BANK_RESET      4'h0
`define CRRE_STACK_DEPTH     31
`define CRRE_SP_W            5
`define CRRE_Q_RESET_START   2'h1
`endif

// *** crre_exec.sv ***
// Executes relative call, software reset, interrupt and literal returns
// What this block does
// - Top five bits 11011 mean relative call with an 11-bit signed offset.
// - The call pushes counter plus two before the counter changes.
// - The call loads counter+2+2n in two cycles and keeps the flags.
// - Word 0x00FF puts every register and flag at its reset value, except the phase count, the stack entries and the reset pulse, which it sets.
// - Word 0x0010/0x0011 pops the stack and loads its top into the counter.
// - The interrupt return sets the high or low priority global enable.
// - With the fast bit set, accumulator, flags, bank reload from shadows.
// - The literal return word 0x0Ckk writes the literal to the accumulator.
// - The literal return pops the stack into the counter in two cycles.
// - Both returns leave the counter high and upper latches as they were.
`timescale 1ns/10ps
`include "crre_consts.svh"
module crre_exec (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             instr_valid,
  input  wire logic [15:0]      instr_word,
  input  wire logic             irq_from_low,
  input  wire logic             pc_fetch_step,
  output crre_pkg::crre_pc_type pc,
  output logic [7:0]            accumulator,
  output logic [4:0]            flags,
  output logic [3:0]            bank_pointer,
  output logic [7:0]            pc_high_latch,
  output logic [4:0]            pc_upper_latch,
  output logic                  high_prio_global_irq_enable,
  output logic                  low_prio_global_irq_enable,
  output logic                  soft_reset_pulse,
  output logic                  instr_busy,
  output crre_pkg::crre_pc_type stack_top
);
  import crre_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    crre_state_type st;
    crre_phase_type phase;
    crre_op_type    op;
    logic [15:0]    word;
    crre_pc_type    pc;
    logic [7:0]     acc;
    logic [4:0]     flags;
    logic [3:0]     bank;
    logic [7:0]     acc_sh;
    logic [4:0]     flags_sh;
    logic [3:0]     bank_sh;
    logic [7:0]     lath;
    logic [4:0]     latu;
    logic           gieh;
    logic           giel;
    logic           srst;
  } crre_state_struct_type;

  crre_state_struct_type s_q, s_d;
  crre_stack_if stk ();

  crre_return_stack u_stack (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .stk     (stk)
  );

  // ****************************************
  // Decode
  // ****************************************
  crre_op_type dec_op;
  crre_pc_type rel_target;
  logic        fast_bit;

  always_comb begin
    dec_op = CRRE_OP_NONE;
    if (instr_word[15:11] == `CRRE_RELATIVE_CALL_OP_TOP5) begin
      dec_op = CRRE_OP_CALL;
    end else if (instr_word == `CRRE_SWRESET_WORD) begin
      dec_op = CRRE_OP_RESET;
    end else if (instr_word[15:1] == `CRRE_IRET_TOP15) begin
      dec_op = CRRE_OP_IRET;
    end else if (instr_word[15:8] == `CRRE_LRET_TOP8) begin
      dec_op = CRRE_OP_LRET;
    end
  end

  // Sign-extend offset, double it: word addressing
  assign rel_target = s_q.pc + `CRRE_PC_STEP
                    + {{(`CRRE_PC_W-12){s_q.word[10]}},
                       s_q.word[10:0], 1'b0};
  assign fast_bit = s_q.word[0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.srst = 1'b0;
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.clear = 1'b0;
    stk.push_value = s_q.pc + `CRRE_PC_STEP;
    s_d.phase = s_q.phase + 2'h1;
    if (pc_fetch_step && s_q.phase == 2'h3 && s_q.st == CRRE_RUN) begin
      s_d.pc = s_q.pc + `CRRE_PC_STEP;
    end
    unique case (s_q.st)
      CRRE_RUN: begin
        if (s_q.phase == 2'h0) begin
          s_d.op = instr_valid ? dec_op : CRRE_OP_NONE;
          s_d.word = instr_word;
        end
        unique case (s_q.op)
          CRRE_OP_CALL: begin
            if (s_q.phase == 2'h1) begin
              stk.push = 1'b1;
            end
            if (s_q.phase == 2'h3) begin
              s_d.pc = rel_target;
              s_d.st = CRRE_FLUSH;
            end
          end
          CRRE_OP_RESET: begin
            if (s_q.phase == `CRRE_Q_RESET_START) begin
              s_d = '0;
              s_d.phase = s_q.phase + 2'h1;
              s_d.pc = `CRRE_PC_RESET;
              s_d.acc = `CRRE_ACC_RESET;
              s_d.flags = `CRRE_FLAGS_RESET;
              s_d.bank = `CRRE_BANK_RESET;
              s_d.srst = 1'b1;
              stk.clear = 1'b1;
            end
          end
          CRRE_OP_IRET, CRRE_OP_LRET: begin
            if (s_q.phase == 2'h3) begin
              // Latches untouched on purpose
              s_d.pc = stk.top;
              stk.pop = 1'b1;
              s_d.st = CRRE_FLUSH;
              if (s_q.op == CRRE_OP_LRET) begin
                s_d.acc = s_q.word[7:0];
              end else begin
                if (irq_from_low) begin
                  s_d.giel = 1'b1;
                end else begin
                  s_d.gieh = 1'b1;
                end
                if (fast_bit) begin
                  s_d.acc = s_q.acc_sh;
                  s_d.flags = s_q.flags_sh;
                  s_d.bank = s_q.bank_sh;
                end
              end
            end
          end
          CRRE_OP_NONE: begin
          end
          default: begin
          end
        endcase
      end
      CRRE_FLUSH: begin
        // Whole cycle idle; prefetched word dropped
        s_d.op = CRRE_OP_NONE;
        if (s_q.phase == 2'h3) begin
          s_d.st = CRRE_RUN;
        end
      end
      default: begin
        s_d.st = CRRE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pc = s_q.pc;
  assign accumulator = s_q.acc;
  assign flags = s_q.flags;
  assign bank_pointer = s_q.bank;
  assign pc_high_latch = s_q.lath;
  assign pc_upper_latch = s_q.latu;
  assign high_prio_global_irq_enable = s_q.gieh;
  assign low_prio_global_irq_enable = s_q.giel;
  assign soft_reset_pulse = s_q.srst;
  assign instr_busy = (s_q.st == CRRE_FLUSH) || (s_q.op != CRRE_OP_NONE);
  assign stack_top = stk.top;
endmodule : crre_exec

// *** crre_exec_properties.sv ***
// Checker for the call, return and reset executor
`timescale 1ns/10ps
`include "crre_consts.svh"
module crre_exec_chk (
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic                  instr_valid,
  input wire logic [15:0]           instr_word,
  input wire logic                  irq_from_low,
  input wire crre_pkg::crre_pc_type pc,
  input wire logic [7:0]            accumulator,
  input wire logic [4:0]            flags,
  input wire logic [7:0]            pc_high_latch,
  input wire logic [4:0]            pc_upper_latch,
  input wire logic                  high_prio_global_irq_enable,
  input wire logic                  low_prio_global_irq_enable,
  input wire logic                  soft_reset_pulse,
  input wire logic                  instr_busy,
  input wire crre_pkg::crre_pc_type stack_top
);
  import crre_pkg::*;
  logic [1:0]  ph_q;
  logic [15:0] w_q;
  crre_pc_type pc0_q;
  crre_pc_type top0_q;
  logic        lo_q;
  logic        take;
  logic        call_w;
  logic        ret_w;
  logic        iret_w;
  assign take = ph_q == 2'h0 && instr_valid && !instr_busy;
  assign call_w = take && instr_word[15:11] == `CRRE_RELATIVE_CALL_OP_TOP5;
  assign iret_w = take && instr_word[15:1] == `CRRE_IRET_TOP15;
  assign ret_w = iret_w || take && instr_word[15:8] == `CRRE_LRET_TOP8;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
  end
  // Data snapshots need no reset: only read after a take
  always_ff @(posedge clk_sys) begin
    if (take) begin
      w_q <= instr_word;
      pc0_q <= pc;
      top0_q <= stack_top;
      lo_q <= irq_from_low;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_push;
    call_w |-> ##2 stack_top == pc0_q + `CRRE_PC_STEP;
  endproperty
  a_push: assert property (p_push)
    else $error("call return address wrong");
  property p_target;
    call_w |-> ##4
      pc == pc0_q + `CRRE_PC_STEP + {{9{w_q[10]}}, w_q[10:0], 1'b0};
  endproperty
  a_target: assert property (p_target)
    else $error("call target wrong");
  property p_flags; call_w |=> $stable(flags)[*4]; endproperty
  a_flags: assert property (p_flags)
    else $error("call touched flags");
  property p_lit;
    take && instr_word[15:8] == `CRRE_LRET_TOP8 |->
      ##4 accumulator == w_q[7:0];
  endproperty
  a_lit: assert property (p_lit)
    else $error("literal not in accumulator");
  property p_ret; ret_w |-> ##4 pc == top0_q; endproperty
  a_ret: assert property (p_ret)
    else $error("return address wrong");
  property p_ena;
    iret_w |-> ##4 (lo_q ? low_prio_global_irq_enable
                         : high_prio_global_irq_enable);
  endproperty
  a_ena: assert property (p_ena)
    else $error("interrupt enable not set");
  property p_latch;
    ret_w |=> ($stable(pc_high_latch) && $stable(pc_upper_latch))[*4];
  endproperty
  a_latch: assert property (p_latch)
    else $error("pc latches changed");
  property p_flush;
    call_w || ret_w |-> ##5 (instr_busy && $stable(pc))[*3];
  endproperty
  a_flush: assert property (p_flush)
    else $error("second cycle not idle");
  property p_sreset;
    take && instr_word == `CRRE_SWRESET_WORD |-> ##[1:3] soft_reset_pulse;
  endproperty
  a_sreset: assert property (p_sreset)
    else $error("no reset pulse");
endmodule : crre_exec_chk
bind crre_exec crre_exec_chk u_crre_exec_chk (.clk_sys, .rst_b, .instr_valid,
  .instr_word, .irq_from_low, .pc, .accumulator, .flags, .pc_high_latch,
  .pc_upper_latch, .high_prio_global_irq_enable, .low_prio_global_irq_enable,
  .soft_reset_pulse, .instr_busy, .stack_top);

// *** crre_pkg.sv ***
// Types for the call, return and reset execution block
`include "crre_consts.svh"
package crre_pkg;
  typedef logic [`CRRE_PC_W-1:0] crre_pc_type;
  typedef logic [1:0] crre_phase_type;
  typedef enum logic [1:0] {CRRE_RUN, CRRE_FLUSH} crre_state_type;
  typedef enum logic [2:0] {
    CRRE_OP_NONE, CRRE_OP_CALL, CRRE_OP_RESET, CRRE_OP_IRET, CRRE_OP_LRET
  } crre_op_type;
endpackage : crre_pkg

// *** crre_return_stack.sv ***
// Hardware return stack held in flip-flops
`timescale 1ns/10ps
`include "crre_consts.svh"
module crre_return_stack (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  crre_stack_if.store stk
);
  import crre_pkg::*;
  typedef struct packed {
    crre_pc_type [`CRRE_STACK_DEPTH-1:0] mem;
    logic [`CRRE_SP_W-1:0]               ptr;
  } crre_stk_state_type;
  crre_stk_state_type s_q, s_d;

  // Ptr counts live entries; overflow wraps silently
  always_comb begin
    s_d = s_q;
    if (stk.clear) begin
      s_d.ptr = '0;
    end else if (stk.push) begin
      // Push past the last entry keeps no value
      if (s_q.ptr < `CRRE_SP_W'(`CRRE_STACK_DEPTH)) begin
        s_d.mem[s_q.ptr] = stk.push_value;
      end
      s_d.ptr = s_q.ptr + `CRRE_SP_W'(1);
    end else if (stk.pop) begin
      s_d.ptr = s_q.ptr - `CRRE_SP_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stk.top = (s_q.ptr == '0) ? `CRRE_PC_RESET
                 : s_q.mem[s_q.ptr - `CRRE_SP_W'(1)];
endmodule : crre_return_stack

// *** crre_stack_if.sv ***
// Interface between the executor and its return stack
`timescale 1ns/10ps
interface crre_stack_if;
  import crre_pkg::*;
  logic        push;
  logic        pop;
  logic        clear;
  crre_pc_type push_value;
  crre_pc_type top;
  modport owner (output push, output pop, output clear,
                 output push_value, input top);
  modport store (input push, input pop, input clear,
                 input push_value, output top);
endinterface : crre_stack_if

// *** tb_top.sv ***
// Self-checking bench for the call, return and reset executor
`timescale 1ns/10ps
`include "crre_consts.svh"
module tb_top;
  import crre_pkg::*;
  typedef struct packed {
    crre_pc_type pc;
    crre_pc_type top;
    logic [7:0]  acc;
    logic [1:0]  ena;
  } crre_note_type;
  logic          clk_sys = 1'b0;
  logic          rst_b = 1'b0;
  logic          instr_valid = 1'b0;
  logic [15:0]   instr_word = 16'h0000;
  logic          irq_from_low = 1'b0;
  logic          pc_fetch_step = 1'b0;
  logic          offer_late = 1'b0;
  crre_pc_type   pc, stack_top, pc_m;
  logic [7:0]    accumulator, acc_m, pc_high_latch, k;
  logic [4:0]    flags, pc_upper_latch;
  logic [3:0]    bank_pointer;
  logic          hi_en, lo_en, soft_reset_pulse, instr_busy;
  logic [1:0]    ph = 2'h0, ena_m;
  logic [15:0]   w;
  crre_pc_type   stk_m[$];
  crre_note_type notes[$];
  crre_note_type nt;
  int            err_total = 0;
  int            compares = 0;
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ph <= rst_b ? ph + 2'h1 : 2'h0;
  crre_exec u_crre_exec (.clk_sys, .rst_b, .instr_valid, .instr_word,
    .irq_from_low, .pc_fetch_step, .pc, .accumulator, .flags, .bank_pointer,
    .pc_high_latch, .pc_upper_latch, .high_prio_global_irq_enable(hi_en),
    .low_prio_global_irq_enable(lo_en), .soft_reset_pulse, .instr_busy,
    .stack_top);
  task automatic check(input string nm, input logic [20:0] s,
                       input logic [20:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic note;
    notes.push_back(crre_note_type'{pc_m,
                                    stk_m.size() ? stk_m[$] : 21'h0,
                                    acc_m, ena_m});
  endtask : note
  // Words go in one clock before a phase 0 edge, then wait for idle
  task automatic issue(input logic [15:0] wd, input logic lo);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ph != 2'h3 && n < 8);
    if (ph != 2'h3) begin
      err_total++;
      stop_test;
    end
    instr_word <= wd;
    irq_from_low <= lo;
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    // Late word rides into the flush cycle, where it must be dropped
    instr_valid <= offer_late;
    instr_word <= offer_late ? {`CRRE_LRET_TOP8, 8'h5A} : 16'($urandom);
    if (offer_late) begin
      repeat (4) @(posedge clk_sys);
      instr_valid <= 1'b0;
    end
    for (n = 0; n < 16; n++) begin
      @(negedge clk_sys);
      if (instr_busy === 1'b0) break;
    end
    if (instr_busy !== 1'b0) begin
      err_total++;
      stop_test;
    end
  endtask : issue
  always @(posedge clk_sys) begin
    if (notes.size() != 0) begin
      nt = notes.pop_front();
      check("pc", pc, nt.pc);
      check("stack_top", stack_top, nt.top);
      check("accumulator", {13'h0, accumulator}, {13'h0, nt.acc});
      check("enables", {19'h0, hi_en, lo_en}, {19'h0, nt.ena});
      check("flags", {16'h0, flags}, 21'h0);
      check("bank", {17'h0, bank_pointer}, 21'h0);
      check("latches", {8'h0, pc_upper_latch, pc_high_latch}, 21'h0);
    end
  end
  initial begin
    void'($urandom(32'h6F9421BA));
    pc_m = 21'h0;
    acc_m = 8'h00;
    ena_m = 2'b00;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    note;
    @(posedge clk_sys);
    pc_fetch_step <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pc_fetch_step <= 1'b0;
    @(negedge clk_sys);
    pc_m = pc_m + `CRRE_PC_STEP;
    note;
    // Both offset extremes first, then random ones
    for (int i = 0; i < 4; i++) begin
      w = {`CRRE_RELATIVE_CALL_OP_TOP5,
           i == 0 ? 11'h400 : i == 1 ? 11'h3FF : 11'($urandom)};
      offer_late = i == 3;
      issue(w, 1'($urandom));
      stk_m.push_back(pc_m + `CRRE_PC_STEP);
      pc_m = pc_m + `CRRE_PC_STEP + {{9{w[10]}}, w[10:0], 1'b0};
      note;
    end
    offer_late = 1'b0;
    issue(16'hF800, 1'b0);
    note;
    k = 8'($urandom) | 8'h80;
    issue({`CRRE_LRET_TOP8, k}, 1'b1);
    acc_m = k;
    pc_m = stk_m.pop_back();
    note;
    issue(16'h0010, 1'b1);
    pc_m = stk_m.pop_back();
    ena_m[0] = 1'b1;
    note;
    issue(16'h0011, 1'b0);
    pc_m = stk_m.pop_back();
    ena_m[1] = 1'b1;
    acc_m = 8'h00;
    note;
    issue(`CRRE_SWRESET_WORD, 1'b1);
    repeat (4) @(negedge clk_sys);
    pc_m = `CRRE_PC_RESET;
    acc_m = `CRRE_ACC_RESET;
    ena_m = 2'b00;
    stk_m.delete();
    note;
    repeat (2) @(posedge clk_sys);
    stop_test;
  end
endmodule : tb_top
